// *** inc/cdt_pkg.sv ***
// opcodes, cycle counts, reset values and types of the cpu tail decoder
// assumes one 100 MHz clock and a byte-wide memory read in the same cycle
package cdt_pkg;

    // opcodes of the single-form instructions
    localparam logic [7:0] OP_SOFTWARE_TRAP = 8'h83; // software_trap_op
    localparam logic [7:0] OP_ACC_TO_INDEX = 8'h97; // acc_to_index_op
    localparam logic [7:0] OP_INDEX_TO_ACC = 8'h9F; // index_to_acc_op
    localparam logic [7:0] OP_WAIT = 8'h8F;
    // low nibble picks the sub or check family, high nibble picks the mode; high nibble 0 is bit branch
    localparam logic [3:0] SUB_LOW_NIBBLE = 4'h0;
    localparam logic [3:0] CHECK_LOW_NIBBLE = 4'hD; // zero_negative_check_op
    localparam logic [3:0] BIT_BRANCH_HIGH = 4'h0;

    // reset values and fixed addresses
    localparam logic [15:0] RESET_PC = 16'h0100;
    localparam logic [7:0] SP_RESET = 8'hFF;
    localparam logic [15:0] TRAP_VECTOR = 16'hFFFC;
    localparam logic [7:0] STACK_PAGE = 8'h00;
    localparam logic [2:0] CCR_PAD = 3'h7;
    localparam logic [2:0] LAST_PUSH = 3'h4;

    // instruction lengths in clock cycles
    localparam logic [3:0] CYC_SUB_LIT = 4'h2;
    localparam logic [3:0] CYC_SUB_DIR = 4'h3;
    localparam logic [3:0] CYC_SUB_FULL = 4'h4;
    localparam logic [3:0] CYC_SUB_IXL = 4'h5;
    localparam logic [3:0] CYC_SUB_IXS = 4'h4;
    localparam logic [3:0] CYC_SUB_IXP = 4'h3;
    localparam logic [3:0] CYC_TRAP = 4'hA;
    localparam logic [3:0] CYC_XFER = 4'h2;
    localparam logic [3:0] CYC_CHK_DIR = 4'h4;
    localparam logic [3:0] CYC_CHK_REG = 4'h3;
    localparam logic [3:0] CYC_CHK_IXS = 4'h5;
    localparam logic [3:0] CYC_CHK_IXP = 4'h4;
    localparam logic [3:0] CYC_BIT_BRANCH = 4'h5;
    localparam logic [3:0] CYC_WAIT = 4'h2;
    localparam logic [3:0] CYC_OTHER = 4'h2;

    typedef enum logic [2:0] {
        MODE_NONE, MODE_LIT, MODE_DIR, MODE_FULL, MODE_IXL, MODE_IXS,
        MODE_IXP
    } cdt_mode_type;

    typedef enum logic [2:0] {
        KIND_OTHER, KIND_SUB, KIND_CHECK, KIND_TAX, KIND_TXA, KIND_TRAP,
        KIND_WAIT, KIND_BRBIT
    } cdt_kind_type;

    typedef enum logic [3:0] {
        ST_FETCH, ST_OPR1, ST_OPR2, ST_DATA, ST_EXEC, ST_PUSH, ST_VECH,
        ST_VECL, ST_WAIT, ST_PAD
    } cdt_state_type;

    // condition_flags, kept without the three pad bits
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cdt_flags_type;

    typedef struct packed {
        cdt_state_type st;
        logic [3:0] cnt;
        logic [7:0] op;
        cdt_kind_type kind;
        cdt_mode_type mode;
        logic [15:0] pc;
        logic [7:0] sp;
        logic [7:0] acc;
        logic [7:0] idx;
        cdt_flags_type flags;
        logic [7:0] b1;
        logic [15:0] ea;
        logic [2:0] push_n;
    } cdt_core_type;

endpackage

// *** rtl/cdt_sub_unit.sv ***
// subtractor giving the result and the n, z, c flags
// assumes purely combinational use by the decoder core
`timescale 1ns/1ps
`default_nettype none

module cdt_sub_unit #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] minuend,
    input wire logic [WIDTH-1:0] subtrahend,
    output logic [WIDTH-1:0] diff,
    output logic neg,
    output logic zero,
    output logic borrow
);

    logic [WIDTH:0] wide;

    // extra top bit carries the borrow out
    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        diff = wide[WIDTH-1:0];
        neg = wide[WIDTH-1];
        zero = (wide[WIDTH-1:0] == '0);
        borrow = wide[WIDTH];
    end

endmodule

`default_nettype wire

// *** rtl/cdt_core.sv ***
// decoder and sequencer for the last group of the 8-bit cpu instructions
// assumes memory answers mem_rdata in the same cycle as mem_rd
// Notes on behaviour
// [RULE_01] subtract memory from accumulator, six modes, n z c
// [RULE_02] trap pushes five bytes, sets mask, loads vector
// [RULE_03] accumulator copied to index, flags untouched
// [RULE_04] check operand minus zero, store nothing
// [RULE_05] index copied to accumulator, flags untouched
// [RULE_06] short indexed adds one offset byte to index
// [RULE_07] long indexed adds two-byte offset, high first
// [RULE_08] full address fetched as two bytes, high first
// [RULE_09] plain indexed uses index, no operand bytes
// [RULE_10] bit branch fetches address then offset byte
// [RULE_11] zero to two operand bytes per instruction
// [RULE_12] wait clears mask, halts until interrupt or reset
`timescale 1ns/1ps
`default_nettype none

module cdt_core #(
    parameter logic [15:0] START_PC = cdt_pkg::RESET_PC,
    parameter logic [15:0] TRAP_VEC = cdt_pkg::TRAP_VECTOR
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic irq_req,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic halted,
    output logic [7:0] acc_out,
    output logic [7:0] idx_out,
    output logic [7:0] flags_out,
    output logic [15:0] pc_out
);

    localparam cdt_pkg::cdt_core_type CORE_RESET = '{
        st: cdt_pkg::ST_FETCH, cnt: 4'h0, op: 8'h00,
        kind: cdt_pkg::KIND_OTHER, mode: cdt_pkg::MODE_NONE,
        pc: cdt_pkg::RESET_PC, sp: cdt_pkg::SP_RESET, acc: 8'h00,
        idx: 8'h00, flags: 5'h08, b1: 8'h00, ea: 16'h0000, push_n: 3'h0
    };

    cdt_pkg::cdt_core_type core_q;
    cdt_pkg::cdt_core_type core_d;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_n;
    logic alu_z;
    logic alu_c;
    logic finish_now;
    logic bit_val;
    logic taken;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // family of an opcode
    function automatic cdt_pkg::cdt_kind_type op_kind(input logic [7:0] op);
        if (op == cdt_pkg::OP_SOFTWARE_TRAP) return cdt_pkg::KIND_TRAP;
        if (op == cdt_pkg::OP_ACC_TO_INDEX) return cdt_pkg::KIND_TAX;
        if (op == cdt_pkg::OP_INDEX_TO_ACC) return cdt_pkg::KIND_TXA;
        if (op == cdt_pkg::OP_WAIT) return cdt_pkg::KIND_WAIT;
        if (op[3:0] == cdt_pkg::SUB_LOW_NIBBLE && op[7:4] >= 4'hA)
            return cdt_pkg::KIND_SUB;
        if (op[3:0] == cdt_pkg::CHECK_LOW_NIBBLE && op[7:4] >= 4'h3 &&
            op[7:4] <= 4'h7)
            return cdt_pkg::KIND_CHECK;
        if (op[7:4] == cdt_pkg::BIT_BRANCH_HIGH) return cdt_pkg::KIND_BRBIT;
        return cdt_pkg::KIND_OTHER;
    endfunction

    // addressing mode, which fixes the operand byte count
    function automatic cdt_pkg::cdt_mode_type op_mode(input logic [7:0] op);
        cdt_pkg::cdt_kind_type k;
        k = op_kind(op);
        if (k == cdt_pkg::KIND_SUB) begin
            case (op[7:4])
                4'hA: return cdt_pkg::MODE_LIT;
                4'hB: return cdt_pkg::MODE_DIR;
                4'hC: return cdt_pkg::MODE_FULL;
                4'hD: return cdt_pkg::MODE_IXL;
                4'hE: return cdt_pkg::MODE_IXS;
                default: return cdt_pkg::MODE_IXP;
            endcase
        end
        if (k == cdt_pkg::KIND_CHECK) begin
            case (op[7:4])
                4'h3: return cdt_pkg::MODE_DIR;
                4'h6: return cdt_pkg::MODE_IXS;
                4'h7: return cdt_pkg::MODE_IXP;
                default: return cdt_pkg::MODE_NONE;
            endcase
        end
        if (k == cdt_pkg::KIND_BRBIT) return cdt_pkg::MODE_DIR;
        return cdt_pkg::MODE_NONE;
    endfunction

    // total cycles the instruction occupies
    function automatic logic [3:0] op_cycles(input logic [7:0] op);
        case (op_kind(op))
            cdt_pkg::KIND_SUB: begin
                case (op_mode(op))
                    cdt_pkg::MODE_LIT: return cdt_pkg::CYC_SUB_LIT;
                    cdt_pkg::MODE_DIR: return cdt_pkg::CYC_SUB_DIR;
                    cdt_pkg::MODE_FULL: return cdt_pkg::CYC_SUB_FULL;
                    cdt_pkg::MODE_IXL: return cdt_pkg::CYC_SUB_IXL;
                    cdt_pkg::MODE_IXS: return cdt_pkg::CYC_SUB_IXS;
                    default: return cdt_pkg::CYC_SUB_IXP;
                endcase
            end
            cdt_pkg::KIND_CHECK: begin
                case (op_mode(op))
                    cdt_pkg::MODE_DIR: return cdt_pkg::CYC_CHK_DIR;
                    cdt_pkg::MODE_IXS: return cdt_pkg::CYC_CHK_IXS;
                    cdt_pkg::MODE_IXP: return cdt_pkg::CYC_CHK_IXP;
                    default: return cdt_pkg::CYC_CHK_REG;
                endcase
            end
            cdt_pkg::KIND_TRAP: return cdt_pkg::CYC_TRAP;
            cdt_pkg::KIND_TAX: return cdt_pkg::CYC_XFER;
            cdt_pkg::KIND_TXA: return cdt_pkg::CYC_XFER;
            cdt_pkg::KIND_WAIT: return cdt_pkg::CYC_WAIT;
            cdt_pkg::KIND_BRBIT: return cdt_pkg::CYC_BIT_BRANCH;
            default: return cdt_pkg::CYC_OTHER;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // subtractor operands: the check family subtracts zero
    always_comb begin
        alu_b = (core_q.kind == cdt_pkg::KIND_SUB) ? mem_rdata : 8'h00;
        if (core_q.kind == cdt_pkg::KIND_SUB)
            alu_a = core_q.acc;
        else if (core_q.st == cdt_pkg::ST_EXEC)
            alu_a = core_q.op[4] ? core_q.idx : core_q.acc;
        else
            alu_a = mem_rdata;
    end

    cdt_sub_unit #(
        .WIDTH(8)
    ) u_sub (
        .minuend(alu_a),
        .subtrahend(alu_b),
        .diff(alu_res),
        .neg(alu_n),
        .zero(alu_z),
        .borrow(alu_c)
    );

    // bit test of the direct operand; even opcodes branch on set
    assign bit_val = mem_rdata[core_q.op[3:1]];
    assign taken = core_q.op[0] ? !bit_val : bit_val;
    // last cycle of the instruction's documented length
    assign finish_now = (core_q.cnt >= op_cycles(core_q.op) - 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // sequencer: one bus access per cycle
    always_comb begin
        core_d = core_q;
        mem_addr = core_q.pc;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = 8'h00;
        core_d.cnt = core_q.cnt + 4'h1;
        case (core_q.st)
            cdt_pkg::ST_FETCH: begin
                mem_rd = 1'b1;
                core_d.op = mem_rdata;
                core_d.kind = op_kind(mem_rdata);
                core_d.mode = op_mode(mem_rdata);
                core_d.pc = core_q.pc + 16'h0001;
                core_d.cnt = 4'h1;
                core_d.push_n = 3'h0;
                // operand byte count follows the mode [RULE_11]
                case (op_kind(mem_rdata))
                    cdt_pkg::KIND_SUB, cdt_pkg::KIND_CHECK,
                    cdt_pkg::KIND_BRBIT: begin
                        if (op_mode(mem_rdata) == cdt_pkg::MODE_IXP) begin
                            core_d.ea = {8'h00, core_q.idx}; // [RULE_09]
                            core_d.st = cdt_pkg::ST_DATA;
                        end else if (op_mode(mem_rdata) == cdt_pkg::MODE_NONE)
                            core_d.st = cdt_pkg::ST_EXEC;
                        else
                            core_d.st = cdt_pkg::ST_OPR1;
                    end
                    cdt_pkg::KIND_TAX, cdt_pkg::KIND_TXA:
                        core_d.st = cdt_pkg::ST_EXEC;
                    cdt_pkg::KIND_TRAP: core_d.st = cdt_pkg::ST_PUSH;
                    cdt_pkg::KIND_WAIT: begin
                        core_d.flags.i = 1'b0; // [RULE_12]
                        core_d.st = cdt_pkg::ST_WAIT;
                    end
                    default: core_d.st = cdt_pkg::ST_PAD;
                endcase
            end
            cdt_pkg::ST_OPR1: begin
                mem_rd = 1'b1;
                core_d.pc = core_q.pc + 16'h0001;
                core_d.b1 = mem_rdata;
                core_d.st = cdt_pkg::ST_DATA;
                case (core_q.mode)
                    cdt_pkg::MODE_LIT: begin
                        core_d.acc = alu_res; // [RULE_01]
                        core_d.flags.n = alu_n;
                        core_d.flags.z = alu_z;
                        core_d.flags.c = alu_c;
                        core_d.st = finish_now ? cdt_pkg::ST_FETCH :
                            cdt_pkg::ST_PAD;
                    end
                    cdt_pkg::MODE_DIR: begin
                        core_d.ea = {8'h00, mem_rdata};
                        if (core_q.kind == cdt_pkg::KIND_BRBIT)
                            core_d.st = cdt_pkg::ST_OPR2; // [RULE_10]
                    end
                    cdt_pkg::MODE_IXS:
                        core_d.ea = {8'h00, core_q.idx} +
                            {8'h00, mem_rdata}; // [RULE_06]
                    default: core_d.st = cdt_pkg::ST_OPR2;
                endcase
            end
            cdt_pkg::ST_OPR2: begin
                mem_rd = 1'b1;
                core_d.pc = core_q.pc + 16'h0001;
                core_d.st = cdt_pkg::ST_DATA;
                case (core_q.mode)
                    cdt_pkg::MODE_FULL:
                        core_d.ea = {core_q.b1, mem_rdata}; // [RULE_08]
                    cdt_pkg::MODE_IXL:
                        core_d.ea = {core_q.b1, mem_rdata} +
                            {8'h00, core_q.idx}; // [RULE_07]
                    default: core_d.b1 = mem_rdata; // branch offset [RULE_10]
                endcase
            end
            cdt_pkg::ST_DATA: begin
                mem_rd = 1'b1;
                mem_addr = core_q.ea;
                core_d.st = finish_now ? cdt_pkg::ST_FETCH : cdt_pkg::ST_PAD;
                case (core_q.kind)
                    cdt_pkg::KIND_SUB: begin
                        core_d.acc = alu_res; // [RULE_01]
                        core_d.flags.n = alu_n;
                        core_d.flags.z = alu_z;
                        core_d.flags.c = alu_c;
                    end
                    cdt_pkg::KIND_CHECK: begin
                        core_d.flags.n = alu_n; // [RULE_04]
                        core_d.flags.z = alu_z;
                    end
                    default: begin
                        core_d.flags.c = bit_val;
                        if (taken)
                            core_d.pc = core_q.pc +
                                {{8{core_q.b1[7]}}, core_q.b1}; // [RULE_10]
                    end
                endcase
            end
            cdt_pkg::ST_EXEC: begin
                core_d.st = finish_now ? cdt_pkg::ST_FETCH : cdt_pkg::ST_PAD;
                case (core_q.kind)
                    cdt_pkg::KIND_TAX: core_d.idx = core_q.acc; // [RULE_03]
                    cdt_pkg::KIND_TXA: core_d.acc = core_q.idx; // [RULE_05]
                    default: begin
                        core_d.flags.n = alu_n; // [RULE_04]
                        core_d.flags.z = alu_z;
                    end
                endcase
            end
            cdt_pkg::ST_PUSH: begin
                mem_wr = 1'b1;
                mem_addr = {cdt_pkg::STACK_PAGE, core_q.sp};
                // low pc, high pc, index, accumulator, flags [RULE_02]
                case (core_q.push_n)
                    3'h0: mem_wdata = core_q.pc[7:0];
                    3'h1: mem_wdata = core_q.pc[15:8];
                    3'h2: mem_wdata = core_q.idx;
                    3'h3: mem_wdata = core_q.acc;
                    default: mem_wdata = {cdt_pkg::CCR_PAD, core_q.flags};
                endcase
                core_d.sp = core_q.sp - 8'h01;
                core_d.push_n = core_q.push_n + 3'h1;
                if (core_q.push_n == cdt_pkg::LAST_PUSH)
                    core_d.st = cdt_pkg::ST_VECH;
            end
            cdt_pkg::ST_VECH: begin
                mem_rd = 1'b1;
                mem_addr = TRAP_VEC;
                core_d.flags.i = 1'b1; // [RULE_02]
                core_d.pc = {mem_rdata, core_q.pc[7:0]};
                core_d.st = cdt_pkg::ST_VECL;
            end
            cdt_pkg::ST_VECL: begin
                mem_rd = 1'b1;
                mem_addr = TRAP_VEC + 16'h0001;
                core_d.pc = {core_q.pc[15:8], mem_rdata};
                core_d.st = finish_now ? cdt_pkg::ST_FETCH : cdt_pkg::ST_PAD;
            end
            cdt_pkg::ST_WAIT: begin
                // core frozen; an interrupt request or reset wakes it [RULE_12]
                core_d.cnt = core_q.cnt;
                if (irq_req)
                    core_d.st = cdt_pkg::ST_FETCH;
            end
            cdt_pkg::ST_PAD: begin
                if (finish_now)
                    core_d.st = cdt_pkg::ST_FETCH;
            end
            default: core_d.st = cdt_pkg::ST_FETCH;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_q <= CORE_RESET;
        end else begin
            core_q <= core_d;
        end
    end

    // visible core state
    assign halted = (core_q.st == cdt_pkg::ST_WAIT);
    assign acc_out = core_q.acc;
    assign idx_out = core_q.idx;
    assign flags_out = {cdt_pkg::CCR_PAD, core_q.flags};
    assign pc_out = core_q.pc;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic at_fetch;
    assign at_fetch = (core_q.st == cdt_pkg::ST_FETCH);

    sub_literal_a: assert property (at_fetch && mem_rdata == 8'hA0 |=> ##1
        (at_fetch && acc_out == $past(acc_out) - $past(mem_rdata)))
        else $error("literal subtract wrong"); // [RULE_01]
    trap_length_a: assert property (at_fetch && mem_rdata == 8'h83 |->
        ##10 (at_fetch && flags_out[3] && core_q.sp == $past(core_q.sp, 10)
        - 8'h05)) else $error("trap length or stack wrong"); // [RULE_02]
    trap_push_a: assert property (at_fetch && mem_rdata == 8'h83 |=>
        (mem_wr && mem_wdata == pc_out[7:0]) ##1
        (mem_wr && mem_wdata == pc_out[15:8]))
        else $error("trap push order wrong"); // [RULE_02]
    tax_copy_a: assert property (at_fetch && mem_rdata == 8'h97 |=> ##1
        (at_fetch && idx_out == $past(acc_out) &&
        flags_out == $past(flags_out, 2)))
        else $error("acc to index wrong"); // [RULE_03]
    check_nostore_a: assert property (at_fetch && mem_rdata == 8'h3D |=>
        (!mem_wr && acc_out == $past(acc_out)) [*3] ##1 at_fetch)
        else $error("check stored or wrong length"); // [RULE_04]
    txa_copy_a: assert property (at_fetch && mem_rdata == 8'h9F |=> ##1
        (at_fetch && acc_out == $past(idx_out)))
        else $error("index to acc wrong"); // [RULE_05]
    short_ix_a: assert property (at_fetch && mem_rdata == 8'hE0 |=> ##1
        (mem_rd && mem_addr == {8'h00, idx_out} + {8'h00, $past(mem_rdata)}))
        else $error("short indexed address wrong"); // [RULE_06]
    long_ix_a: assert property (at_fetch && mem_rdata == 8'hD0 |=> ##2
        (mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)} +
        {8'h00, idx_out})) else $error("long indexed address wrong"); // [RULE_07]
    full_addr_a: assert property (at_fetch && mem_rdata == 8'hC0 |=> ##2
        (mem_rd && mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)}))
        else $error("full address wrong"); // [RULE_08]
    plain_ix_a: assert property (at_fetch && mem_rdata == 8'hF0 |=>
        (mem_rd && mem_addr == {8'h00, idx_out}))
        else $error("plain indexed address wrong"); // [RULE_09]
    wait_mask_a: assert property (at_fetch && mem_rdata == 8'h8F |=>
        (halted && !flags_out[3])) else $error("wait did not halt"); // [RULE_12]

    sub_seen_c: cover property (at_fetch && mem_rdata == 8'hD0);
    trap_seen_c: cover property (core_q.st == cdt_pkg::ST_VECL);
    wake_seen_c: cover property (halted && irq_req);
    branch_seen_c: cover property (core_q.st == cdt_pkg::ST_DATA &&
        core_q.kind == cdt_pkg::KIND_BRBIT && taken);

endmodule

`default_nettype wire

// *** sim/cdt_mem_model.sv ***
// byte-wide program, data and stack memory on the cpu bus
// assumes zero wait states: read data is combinational with mem_rd
`timescale 1ns/1ps
`default_nettype none

module cdt_mem_model (
    input wire logic clk,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // an idle bus shows the inverse of the last byte, never a stale copy
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

    // byte written at the strobe edge
    always @(posedge clk) begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
        if (mem_rd)
            last_q <= mem[mem_addr];
    end
endmodule

`default_nettype wire

// *** sim/cpu_decode_tail_ops_test.sv ***
// self-checking bench for the cpu tail decoder with a memory model
// assumes program at 0x0100, trap vector pointing to 0x0800
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("Error at %0t: got %0h expected %0h", $time, g, e); \
    end \
end

module cpu_decode_tail_ops_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic irq_req = 1'b0;
    logic [7:0] mem_rdata, mem_wdata, acc_out, idx_out, flags_out;
    logic [15:0] mem_addr, pc_out, pa, ret;
    logic mem_rd, mem_wr, halted, fn, fz, fc;
    logic [31:0] seed = 32'h16CA0869;
    logic [7:0] ea, ex, v, o;
    logic [7:0] sk [0:4];
    bit used [0:65535];
    int error_cnt = 0;
    int total_checks = 0;
    int cyc, n;

    // 100 MHz clock
    always #5 clk = ~clk;

    cdt_core dut_u (.clk, .rstn, .irq_req, .mem_rdata, .mem_addr, .mem_rd,
        .mem_wr, .mem_wdata, .halted, .acc_out, .idx_out, .flags_out,
        .pc_out);
    cdt_mem_model mem_u (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
        .mem_rdata);

    ////////////////////////////////////////
    // xorshift source of operand bytes
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] m);
        return {1'b0, a} - {1'b0, m};
    endfunction

    // place a program byte
    task automatic put(input logic [7:0] b);
        mem_u.mem[pa] = b;
        pa = pa + 16'h0001;
    endtask

    // data byte at an address, reusing one already placed there
    task automatic dat(input logic [15:0] a);
        if (!used[a]) begin
            mem_u.mem[a] = rnd();
            used[a] = 1'b1;
        end
        v = mem_u.mem[a];
    endtask

    // expected n and z of a value, plus instruction length
    task automatic tst(input logic [7:0] m, input int c);
        fn = m[7];
        fz = (m == 8'h00);
        cyc += c;
    endtask

    // expected accumulator and flags after a subtract
    task automatic sub(input logic [7:0] m, input int c);
        logic [8:0] r;
        r = sub9(ea, m);
        ea = r[7:0];
        fc = r[8];
        tst(ea, c);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one program through every mode, then trap, transfer and wait
    task automatic run_one(input int k);
        for (int a = 0; a < 65536; a++) begin
            mem_u.mem[a] = 8'h9D;
            used[a] = 1'b0;
        end
        pa = 16'h0100;
        {ea, ex, fn, fz, fc, cyc} = '0;
        v = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : rnd();
        put(8'hA0); put(v); sub(v, 2);
        put(8'h97); ex = ea; cyc += 2;
        o = rnd() & 8'h7F; put(8'hB0); put(o); dat({8'h00, o}); sub(v, 3);
        o = rnd(); put(8'hC0); put(8'h41); put(o); dat({8'h41, o}); sub(v, 4);
        o = rnd(); put(8'hD0); put(8'h50); put(o);
        dat(16'h5000 + {8'h00, o} + {8'h00, ex}); sub(v, 5);
        o = rnd() & ~ex; put(8'hE0); put(o); dat({8'h00, o | ex}); sub(v, 4);
        put(8'hF0); dat({8'h00, ex}); sub(v, 3);
        o = rnd() & 8'h7F; put(8'h3D); put(o); dat({8'h00, o}); tst(v, 4);
        put(8'h4D); tst(ea, 3);
        put(8'h5D); tst(ex, 3);
        o = rnd() & ~ex; put(8'h6D); put(o); dat({8'h00, o | ex}); tst(v, 5);
        put(8'h7D); dat({8'h00, ex}); tst(v, 4);
        o = rnd() & 8'h7F; put(8'h00); put(o); put(8'h02); dat({8'h00, o});
        fc = v[0];
        put(8'h9D); put(8'h9D); cyc += fc ? 5 : 9;
        put(8'h83); ret = pa; cyc += 10;
        sk = '{ret[7:0], ret[15:8], ex, ea, {5'b11101, fn, fz, fc}};
        mem_u.mem[16'hFFFC] = 8'h08;
        mem_u.mem[16'hFFFD] = 8'h00;
        pa = 16'h0800; put(8'h9F); ea = ex; cyc += 2; put(8'h8F);
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (!halted && n < 300);
        `CHK(n, cyc + 1)
        `CHK(acc_out, ea)
        `CHK(idx_out, ex)
        `CHK(pc_out, 16'h0802)
        `CHK(flags_out, {5'b11100, fn, fz, fc})
        for (int i = 0; i < 5; i++)
            `CHK(mem_u.mem[16'h00FF - i], sk[i])
        repeat (3) @(posedge clk);
        #1 `CHK({halted, mem_rd, mem_wr}, 3'b100)
        irq_req = 1'b1;
        @(posedge clk);
        #1 irq_req = 1'b0;
        `CHK({mem_rd, mem_addr}, {1'b1, 16'h0802})
    endtask

    ////////////////////////////////////////
    // main sequence: corner operands first, random ones after
    initial begin
        for (int k = 0; k < 8; k++)
            run_one(k);
        finish_test();
    end

    // watchdog well past eight runs of about 70 cycles
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
endmodule

`default_nettype wire
